// ==== fcd_dev_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// behavioural converter: collects host write words, answers status reads
module fcd_dev_model #(
    parameter logic [26:0] DEF_COEF = 27'h0000001    // arbitrary stand-in for the built-in set
) (
    input  wire logic                 clk_sys_i,     // system clock
    input  wire logic                 nrst_i,        // async reset, active low
    input  wire fcd_pkg::fcd_bus_type bus_i,         // host bus drive
    input  wire logic                 corrupt_i,     // spoil the internal sum on purpose
    output logic [15:0]               data_o         // bus level towards the host
);
    logic [26:0] mem [48];
    logic [15:0] wd, hiw, rx_csum, sum, ctrl_dl, ctrl_last;
    logic        wr_prev, have_addr, in_dl, half, good, post_cs, tog, pad_bad;
    int          ncoef, idx, nbus, wait_cyc, wait_seen;

    ////////////////////////////////////////////////////////////
    // a word counts at the rising write strobe; blocking updates keep the model short
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            foreach (mem[i]) mem[i] = DEF_COEF;
            {wr_prev, tog} = 2'b10;
            {have_addr, in_dl, half, good, post_cs, pad_bad} = '0;
            {wd, hiw, ctrl_dl, ctrl_last, rx_csum, sum} = '0;
            {ncoef, idx, nbus, wait_cyc, wait_seen} = '0;
        end else begin
            tog = ~tog;
            wait_cyc = wait_cyc + 1;
            if (!wr_prev && bus_i.wr_n) begin
                nbus = nbus + 1;
                if (in_dl && !half && idx < ncoef) begin
                    hiw = wd;
                    half = 1'b1;
                end else if (in_dl && idx < ncoef) begin
                    mem[idx] = {hiw[10:0], wd};
                    pad_bad = pad_bad | (hiw[15:11] != 5'h00);
                    sum = sum + hiw[15:8] + hiw[7:0] + wd[15:8] + wd[7:0];
                    idx = idx + 1;
                    half = 1'b0;
                end else if (in_dl) begin
                    rx_csum = wd;
                    good = ((sum + 16'(corrupt_i)) == wd);
                    for (int i = idx; i < 48; i++) mem[i] = '0;
                    in_dl = 1'b0;
                    post_cs = 1'b1;
                    wait_cyc = 0;
                end else if (!have_addr) begin
                    have_addr = (wd == fcd_pkg::CR1_ADDR);
                    if (post_cs) wait_seen = wait_cyc;
                    post_cs = 1'b0;
                end else begin
                    have_addr = 1'b0;
                    ctrl_last = wd;
                    if (wd[fcd_pkg::CR1_DL_BIT]) begin
                        ctrl_dl = wd;
                        {half, good, pad_bad, sum} = '0;
                        in_dl = 1'b1;
                        idx = 0;
                        ncoef = (wd[8:5] == 4'h0) ? 0 : (int'(wd[8:6]) + 1) * 6;
                    end
                end
            end
            wr_prev = bus_i.wr_n;
            if (!bus_i.cs_n && !bus_i.wr_n) wd = bus_i.data;
        end
    end

    // released bus flips every cycle so a stale level can never pass for status
    assign data_o = (!bus_i.cs_n && !bus_i.rd_n) ? {8'h00, good, 7'h00} : {16{tog}};
endmodule : fcd_dev_model

// ==== fcd_host.sv ====
// Contract
// - coefficients are sign and 26-bit magnitude, sign one means negative.
// - host only loads 12 to 96 taps in steps of 12.
// - half as many coefficients as taps are sent; device mirrors them.
// - coefficients go from the symmetry point outward, stored in that order.
// - host scales low-pass half-response to sum 67108863 for unity gain.
// - each 27-bit coefficient is zero-padded to 32 bits, sent as two words.
// - first word is five zeros, sign, mag 25..16; second is mag 15..0.
// - checksum is 16-bit byte sum of all words, sent after last coefficient.
// - download starts by writing control one with enable and length code.
// - upper word then lower word per coefficient, then checksum word.
// - download-ok is read back from the status register or with data.
// - a register write is an address word then one data word.
// - control register one sits at address 0x0001.
`timescale 1ns/1ps
module fcd_host (
    input  wire logic                 clk_sys_i,             // system clock, 25 MHz
    input  wire logic                 nrst_i,                // async reset, active low
    input  wire logic                 start_i,               // one-cycle download request
    input  wire logic [3:0]           tap_count_code_i,      // filter length code
    input  wire logic [4:0]           ctrl_low_i,            // bypass and decimation bits kept
    input  wire logic                 coef_valid_i,          // coefficient offered
    input  wire fcd_pkg::fcd_coef_type coef_i,               // coefficient, centre outward
    output logic                      coef_ready_o,          // controller in fetch; coefficient taken this cycle if offered
    output logic                      busy_o,                // sequence running
    output logic                      done_o,                // one-cycle end pulse
    output logic                      coef_load_good_flag_o, // download verified
    output logic                      code_error_o,          // last request refused
    output fcd_pkg::fcd_bus_type      bus_o,                 // parallel bus drive
    input  wire logic [15:0]          data_i                 // parallel bus read level
);

    ////////////////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed {
        fcd_pkg::fcd_state_type st;
        logic [1:0]             ph;      // bus phase
        logic [5:0]             idx;     // coefficients sent
        logic [5:0]             total;   // coefficients to send
        logic [15:0]            hw;      // upper word of current coefficient
        logic [15:0]            lw;      // lower word of current coefficient
        logic [15:0]            sum;     // running checksum
        logic [11:0]            zwait;   // slot zeroing countdown
        logic [15:0]            ctrl;    // control word in use
        fcd_pkg::fcd_bus_type   bus;
        logic                   sy1;     // status bit synchroniser stage one
        logic                   sy2;
        logic                   busy;
        logic                   done;
        logic                   good;
        logic                   err;
    } fcd_regs_type;

    fcd_regs_type r;
    fcd_regs_type next_r;

    // coefficients to send for an odd code: six per step
    function automatic logic [5:0] coef_count(input logic [3:0] code);
        coef_count = 6'((({3'b000, code[3:1]}) + 6'h01) * fcd_pkg::COEF_STEP);
    endfunction : coef_count

    // byte sum of both padded words, modulo 65536
    function automatic logic [15:0] byte_sum(input logic [15:0] a, input logic [15:0] b);
        logic [9:0] s;
        s = 10'(a[15:8]) + 10'(a[7:0]) + 10'(b[15:8]) + 10'(b[7:0]);
        byte_sum = {6'h00, s};
    endfunction : byte_sum

    logic bad_code;
    logic last_coef;
    assign bad_code  = (tap_count_code_i == 4'h0) || !tap_count_code_i[0];
    assign last_coef = (r.idx + 6'h01) == r.total;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: every bus cycle is four clocks, write strobe low for the first two, read strobe low for all four
    always_comb begin
        logic [15:0] word;
        word            = 16'h0000;
        next_r          = r;
        next_r.done     = 1'b0;
        next_r.sy1      = data_i[fcd_pkg::STAT_GOOD_BIT];
        next_r.sy2      = r.sy1;
        if (r.st != fcd_pkg::ST_IDLE && r.st != fcd_pkg::ST_FETCH &&
            r.st != fcd_pkg::ST_ZWAIT) begin
            next_r.ph = r.ph + 2'h1;
        end
        case (r.st)
            fcd_pkg::ST_IDLE: begin
                if (start_i) begin
                    if (bad_code) begin
                        next_r.err  = 1'b1;
                        next_r.done = 1'b1;
                    end else begin
                        next_r.ctrl = 16'h0000;
                        next_r.ctrl[fcd_pkg::CR1_DL_BIT] = 1'b1;
                        next_r.ctrl[fcd_pkg::CR1_LEN_LSB +: 4] = tap_count_code_i;
                        next_r.ctrl[4:0] = ctrl_low_i;
                        next_r.total = coef_count(tap_count_code_i);
                        next_r.idx   = 6'h00;
                        next_r.sum   = 16'h0000;
                        next_r.err   = 1'b0;
                        next_r.good  = 1'b0;
                        next_r.busy  = 1'b1;
                        next_r.ph    = 2'h0;
                        next_r.st    = fcd_pkg::ST_ADDR;
                    end
                end
            end
            fcd_pkg::ST_ADDR: begin
                if (r.ph == 2'h3) next_r.st = fcd_pkg::ST_CTRL;
            end
            fcd_pkg::ST_CTRL: begin
                if (r.ph == 2'h3) next_r.st = fcd_pkg::ST_FETCH;
            end
            fcd_pkg::ST_FETCH: begin
                // the coefficient source may stall here for as long as it likes
                if (coef_valid_i) begin
                    next_r.hw  = {{fcd_pkg::PAD_W{1'b0}}, coef_i.sign, coef_i.mag[25:16]};
                    next_r.lw  = coef_i.mag[15:0];
                    next_r.sum = r.sum + byte_sum({{fcd_pkg::PAD_W{1'b0}}, coef_i.sign,
                                                   coef_i.mag[25:16]}, coef_i.mag[15:0]);
                    next_r.ph  = 2'h0;
                    next_r.st  = fcd_pkg::ST_HI;
                end
            end
            fcd_pkg::ST_HI: begin
                if (r.ph == 2'h3) next_r.st = fcd_pkg::ST_LO;
            end
            fcd_pkg::ST_LO: begin
                if (r.ph == 2'h3) begin
                    next_r.idx = r.idx + 6'h01;
                    next_r.st  = last_coef ? fcd_pkg::ST_CSUM : fcd_pkg::ST_FETCH;
                end
            end
            fcd_pkg::ST_CSUM: begin
                if (r.ph == 2'h3) begin
                    next_r.zwait = 12'((fcd_pkg::MAX_COEF - r.total) * fcd_pkg::ZERO_CYC);
                    next_r.st    = fcd_pkg::ST_ZWAIT;
                end
            end
            fcd_pkg::ST_ZWAIT: begin
                if (r.zwait == 12'h000) begin
                    next_r.ph = 2'h0;
                    next_r.st = fcd_pkg::ST_ADDR2;
                end else begin
                    next_r.zwait = r.zwait - 12'h001;
                end
            end
            fcd_pkg::ST_ADDR2: begin
                if (r.ph == 2'h3) begin
                    next_r.ctrl[fcd_pkg::CR1_DL_BIT]   = 1'b0;
                    next_r.ctrl[fcd_pkg::CR1_RDST_BIT] = 1'b1;
                    next_r.st = fcd_pkg::ST_STAT;
                end
            end
            fcd_pkg::ST_STAT: begin
                if (r.ph == 2'h3) next_r.st = fcd_pkg::ST_READ;
            end
            fcd_pkg::ST_READ: begin
                // sy2 has seen the read level for two edges by phase three
                if (r.ph == 2'h3) begin
                    next_r.good = r.sy2;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.st   = fcd_pkg::ST_IDLE;
                end
            end
            default: next_r.st = fcd_pkg::ST_IDLE;
        endcase

        // bus pins follow the next state so strobes leave flip-flops clean
        case (next_r.st)
            fcd_pkg::ST_ADDR, fcd_pkg::ST_ADDR2: word = fcd_pkg::CR1_ADDR;
            fcd_pkg::ST_CTRL, fcd_pkg::ST_STAT:  word = next_r.ctrl;
            fcd_pkg::ST_HI:                      word = next_r.hw;
            fcd_pkg::ST_LO:                      word = next_r.lw;
            fcd_pkg::ST_CSUM:                    word = next_r.sum;
            default:                             word = 16'h0000;
        endcase
        next_r.bus.cs_n = 1'b1;
        next_r.bus.wr_n = 1'b1;
        next_r.bus.rd_n = 1'b1;
        next_r.bus.oe   = 1'b0;
        if (next_r.st == fcd_pkg::ST_READ) begin
            next_r.bus.cs_n = 1'b0;
            next_r.bus.rd_n = 1'b0;
        end else if (next_r.st != fcd_pkg::ST_IDLE && next_r.st != fcd_pkg::ST_FETCH &&
                     next_r.st != fcd_pkg::ST_ZWAIT) begin
            next_r.bus.cs_n = next_r.ph[1];
            next_r.bus.wr_n = next_r.ph[1];
            next_r.bus.oe   = (next_r.ph != 2'h3);  // data held past the rising strobe
            next_r.bus.data = word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r          <= '0;
            r.bus.cs_n <= 1'b1;
            r.bus.wr_n <= 1'b1;
            r.bus.rd_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign coef_ready_o          = (r.st == fcd_pkg::ST_FETCH);
    assign busy_o                = r.busy;
    assign done_o                = r.done;
    assign coef_load_good_flag_o = r.good;
    assign code_error_o          = r.err;
    assign bus_o                 = r.bus;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    chk_wr_pulse_width: assert property ($fell(bus_o.wr_n) |-> ##1 !bus_o.wr_n ##1 bus_o.wr_n)
        else $error("write strobe not two cycles");
    chk_data_held: assert property ($rose(bus_o.wr_n) |-> $stable(bus_o.data) && bus_o.oe)
        else $error("data changed at write strobe rise");
    chk_addr_word: assert property ((r.st == fcd_pkg::ST_ADDR) && !bus_o.wr_n |->
        bus_o.data == fcd_pkg::CR1_ADDR) else $error("wrong register address");
    chk_dl_enable_word: assert property ((r.st == fcd_pkg::ST_CTRL) && !bus_o.wr_n |->
        bus_o.data[fcd_pkg::CR1_DL_BIT] && bus_o.data[fcd_pkg::CR1_LEN_LSB] &&
        (bus_o.data[fcd_pkg::CR1_LEN_LSB +: 4] != 4'h0))
        else $error("control write lacks enable or length");
    chk_hi_padding: assert property ((r.st == fcd_pkg::ST_HI) && !bus_o.wr_n |->
        bus_o.data[15:11] == 5'h00) else $error("upper word not zero padded");
    chk_coef_order: assert property (coef_ready_o && coef_valid_i |=> (r.st == fcd_pkg::ST_HI)
        && r.hw[10:0] == {$past(coef_i.sign), $past(coef_i.mag[25:16])}
        && r.lw == $past(coef_i.mag[15:0])) else $error("coefficient words wrong");
    chk_lo_after_hi: assert property ((r.st == fcd_pkg::ST_HI) && (r.ph == 2'h3) |=>
        (r.st == fcd_pkg::ST_LO) ##1 !bus_o.wr_n) else $error("lower word not next");
    chk_count_match: assert property ((r.st == fcd_pkg::ST_LO) && (r.ph == 2'h3) |->
        ##1 ((r.st == fcd_pkg::ST_CSUM) == (r.idx == r.total)))
        else $error("coefficient count wrong");
    chk_csum_word: assert property ((r.st == fcd_pkg::ST_CSUM) && !bus_o.wr_n |->
        bus_o.data == r.sum) else $error("checksum word wrong");
    chk_zero_wait: assert property ($rose(r.st == fcd_pkg::ST_ZWAIT) |->
        r.zwait == 12'((fcd_pkg::MAX_COEF - r.total) * fcd_pkg::ZERO_CYC))
        else $error("zeroing wait wrong");
    chk_bad_code: assert property (start_i && (r.st == fcd_pkg::ST_IDLE) && bad_code |=>
        code_error_o && done_o && (r.st == fcd_pkg::ST_IDLE)) else $error("bad code not refused");
    chk_stat_read: assert property ((r.st == fcd_pkg::ST_STAT) && !bus_o.wr_n |->
        bus_o.data[fcd_pkg::CR1_RDST_BIT] && !bus_o.data[fcd_pkg::CR1_DL_BIT])
        else $error("status select write wrong");

    cov_good_load: cover property (done_o && coef_load_good_flag_o);
    cov_refused:   cover property (done_o && code_error_o);
    cov_stall:     cover property (coef_ready_o && !coef_valid_i ##1 coef_ready_o && coef_valid_i);

endmodule : fcd_host

// ==== fcd_pkg.sv ====
////////////////////////////////////////////////////////////////////////////////
// constants and carriers for the coefficient download controller
package fcd_pkg;

    // timing of the host side
    localparam int CLK_NS         = 40;                  // system clock period
    localparam int ICLK_NS        = 100;                 // device internal clock period
    localparam int ZERO_NS        = ICLK_NS / 2;         // slot zeroing time per coefficient
    localparam int ZERO_CYC_RAW   = (ZERO_NS + CLK_NS - 1) / CLK_NS;
    localparam int ZERO_CYC       = (ZERO_CYC_RAW < 1) ? 1 : ZERO_CYC_RAW;

    // device map and field layout
    localparam logic [15:0] CR1_ADDR      = 16'h0001;    // control register one address
    localparam int          CR1_DL_BIT    = 15;          // download-filter enable
    localparam int          CR1_RDST_BIT  = 11;          // read status select
    localparam int          CR1_LEN_LSB   = 5;           // tap_count_code position
    localparam int          STAT_GOOD_BIT = 7;           // coef_load_good_flag position
    localparam logic [5:0]  MAX_COEF      = 6'h30;       // 48 half-response slots
    localparam logic [5:0]  COEF_STEP     = 6'h06;       // coefficients per length step
    localparam int          MAG_W         = 26;          // magnitude bits
    localparam int          PAD_W         = 5;           // zero padding above the sign

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_ADDR  = 4'b0001,
        ST_CTRL  = 4'b0010,
        ST_FETCH = 4'b0011,
        ST_HI    = 4'b0100,
        ST_LO    = 4'b0101,
        ST_CSUM  = 4'b0110,
        ST_ZWAIT = 4'b0111,
        ST_ADDR2 = 4'b1000,
        ST_STAT  = 4'b1001,
        ST_READ  = 4'b1010
    } fcd_state_type;

    // one coefficient in sign and magnitude form
    typedef struct packed {
        logic             sign;                          // 1 = negative
        logic [MAG_W-1:0] mag;
    } fcd_coef_type;

    // parallel bus pins driven by the host
    typedef struct packed {
        logic        cs_n;
        logic        wr_n;
        logic        rd_n;
        logic        oe;
        logic [15:0] data;
    } fcd_bus_type;

endpackage : fcd_pkg

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    localparam logic [26:0] DEFC = 27'h0000001;   // arbitrary default set marker
    logic                  clk_sys_i, nrst_i, start_i, coef_valid_i, corrupt;
    logic [3:0]            tap_count_code_i;
    logic [4:0]            ctrl_low_i;
    fcd_pkg::fcd_coef_type coef_i;
    logic                  coef_ready_o, busy_o, done_o, coef_load_good_flag_o, code_error_o;
    fcd_pkg::fcd_bus_type  bus_o;
    logic [15:0]           data_i;
    fcd_pkg::fcd_coef_type cf [48];
    int                    error_cnt, checks, cyc;
    int tbl [12] = '{53188232, 29300796, 1402406, -11017834, -6236822, 2902466,
                     5302774, 1104856, -3137108, -3621978, -1801582, -277343};

    fcd_host dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .start_i(start_i),
        .tap_count_code_i(tap_count_code_i), .ctrl_low_i(ctrl_low_i),
        .coef_valid_i(coef_valid_i), .coef_i(coef_i), .coef_ready_o(coef_ready_o),
        .busy_o(busy_o), .done_o(done_o), .coef_load_good_flag_o(coef_load_good_flag_o),
        .code_error_o(code_error_o), .bus_o(bus_o), .data_i(data_i));
    fcd_dev_model #(.DEF_COEF(DEFC)) model (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .bus_i(bus_o), .corrupt_i(corrupt), .data_o(data_i));

    ////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task check(input logic ok, input string msg);
        checks++;
        // an unknown result counts as a mismatch, never as a pass
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check

    task print_verdict;
        $display("error_cnt %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // byte sum of the padded words, wrapped at 16 bits
    function logic [15:0] csum(input int n);
        logic [31:0] w;
        logic [15:0] s;
        s = '0;
        for (int i = 0; i < n; i++) begin
            w = {5'h00, cf[i]};
            s = s + w[31:24] + w[23:16] + w[15:8] + w[7:0];
        end
        return s;
    endfunction : csum

    // one download; a start while busy is thrown in and must be ignored
    task run_dl(input logic [3:0] code, input logic bad);
        int         n;
        int         k;
        logic [4:0] lo;
        n = (int'(code[3:1]) + 1) * 6;
        lo = 5'($urandom);
        corrupt <= bad;
        start_i <= 1'b1;
        tap_count_code_i <= code;
        ctrl_low_i <= lo;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        start_i <= 1'b1;
        tap_count_code_i <= 4'h0;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        for (int i = 0; i < n; i++) begin
            // a random gap of up to 15 cycles before most coefficients; only gaps longer than five cycles before the first one,
            // or than the eight cycles of the two word writes before each later one, make the controller wait in fetch
            k = int'($urandom % 16);
            if (k > 0) begin
                coef_valid_i <= 1'b0;
                repeat (k) @(posedge clk_sys_i);
            end
            coef_valid_i <= 1'b1;
            coef_i <= cf[i];
            k = 0;
            do begin @(posedge clk_sys_i); k++; end while (coef_ready_o !== 1'b1 && k < 100);
        end
        coef_valid_i <= 1'b0;
        k = 0;
        do begin @(posedge clk_sys_i); k++; end while (done_o !== 1'b1 && k < 3000);
        @(posedge clk_sys_i);
        check(coef_load_good_flag_o === !bad, "download flag");
        check(code_error_o === 1'b0 && busy_o === 1'b0, "busy start not ignored");
        check(model.ctrl_dl === {1'b1, 6'h00, code, lo}, "download control word");
        check(model.ctrl_last === {4'h0, 1'b1, 2'h0, code, lo}, "readback control");
        check(model.rx_csum === csum(n) && model.pad_bad === 1'b0, "checksum word");
        check(model.wait_seen >= (48 - n) * fcd_pkg::ZERO_CYC, "zero fill wait");
        for (int i = 0; i < 48; i++)
            check(model.mem[i] === (i < n ? 27'(cf[i]) : 27'h0), "coefficient slot");
    endtask : run_dl

    // hang guard
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////
    initial begin
        int k;
        {nrst_i, start_i, coef_valid_i, corrupt} = '0;
        {tap_count_code_i, ctrl_low_i, coef_i} = '0;
        {cyc, error_cnt, checks} = '0;
        void'($urandom(32'hbc26d324));
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        check(coef_load_good_flag_o === 1'b0 && model.mem[0] === DEFC, "reset state");
        // worked example with a known checksum
        foreach (tbl[i]) cf[i] = {tbl[i] < 0, 26'(tbl[i] < 0 ? -tbl[i] : tbl[i])};
        check(csum(12) === 16'h0e6b, "example checksum");
        k = 0;
        foreach (tbl[i]) k += tbl[i];
        check(k == 67108863, "unity gain example");
        run_dl(4'h3, 1'b0);
        // every odd length code with random coefficients, then a spoiled device sum
        for (int c = 1; c < 16; c += 2) begin
            foreach (cf[i]) cf[i] = {1'($urandom), 26'($urandom)};
            run_dl(4'(c), 1'b0);
        end
        run_dl(4'hf, 1'b1);
        corrupt <= 1'b0;
        // refused codes: zero and an even value leave the bus alone
        for (int j = 0; j < 2; j++) begin
            k = model.nbus;
            start_i <= 1'b1;
            tap_count_code_i <= 4'(j * 8);
            @(posedge clk_sys_i);
            start_i <= 1'b0;
            repeat (3) @(posedge clk_sys_i);
            check(code_error_o === 1'b1 && model.nbus == k, "refused code");
            check(coef_load_good_flag_o === 1'b0, "flag kept on refusal");
        end
        // reset in mid download brings back the built-in set
        start_i <= 1'b1;
        tap_count_code_i <= 4'h1;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        check(bus_o.cs_n === 1'b1 && busy_o === 1'b0 && model.mem[0] === DEFC, "reset wipe");
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        check(bus_o.cs_n === 1'b1 && coef_ready_o === 1'b0 && done_o === 1'b0,
              "idle after release");
        print_verdict();
    end
endmodule : testbench
